// File: hw/irq_mask_pkg.sv
// package for the extended interrupt enable mask register block
// assumes an 8-bit special-function register bus inside the core
`default_nettype none
package irq_mask_pkg;
  localparam logic [7:0] EXT_IRQ_EN2_ADDR = 8'hE7;
  localparam logic [7:0] EXT_IRQ_EN2_RESET = 8'h00;
  localparam logic [7:0] EXT_OSC_CONTROL_ADDR = 8'hB1;
  localparam int XTAL_EN_BIT = 7;
  localparam int RSVD_HI_BIT = 6;
  localparam int SOFT_EN_LSB = 2;
  localparam int SOFT_EN_MSB = 5;
  localparam int CONV_EN_BIT = 1;
  localparam int RSVD_LO_BIT = 0;
  localparam int CRYSTAL_STABLE_BIT = 7;
  // writable bits of the enable register; bits 6 and 0 always hold zero
  localparam logic [7:0] EXT_IRQ_EN2_WMASK = 8'hBE;
  localparam int SOFT_IRQ_COUNT = 4;
endpackage : irq_mask_pkg
`default_nettype wire

// File: hw/irq_gate.sv
// one masked interrupt source: pending flag ANDed with its enable bit
// assumes the pending flag is held by its owning unit
`default_nettype none
module irq_gate (
  input wire logic pending,
  input wire logic enable,
  output logic request
);
  assign request = pending & enable;
endmodule : irq_gate
`default_nettype wire

// File: hw/ext_irq_enable.sv
// extended interrupt enable register 2 and its masking of six sources
// assumes a single-cycle special-function register bus from the core
`default_nettype none
// Notes on behaviour
// - bit 7 gates crystal-stable interrupt requests
// - bit 6 reserved, reads 0, write 0
// - bits 5..2 mask soft interrupts 3..0
// - soft request reaches core only when enabled
// - bit 1 masks conversion-done interrupt
// - crystal-stable flag is oscillator control bit 7
module ext_irq_enable
  import irq_mask_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [7:0] ext_osc_control,
  input wire logic [SOFT_IRQ_COUNT-1:0] soft_irq_flag,
  input wire logic conv_done_flag,
  output logic crystal_stable_req,
  output logic [SOFT_IRQ_COUNT-1:0] soft_irq_req,
  output logic conv_done_req
);
  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------
  logic [7:0] irq_en;
  logic en_write;
  logic crystal_stable_flag;
  logic crystal_stable_irq_en;
  logic conv_done_irq_en;
  logic [SOFT_IRQ_COUNT-1:0] soft_en;

  assign en_write = sfr_wr && (sfr_addr == EXT_IRQ_EN2_ADDR);

  // reserved bits are masked off so a stray 1 can never enable anything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en <= EXT_IRQ_EN2_RESET;
    end else if (en_write) begin
      irq_en <= sfr_wdata & EXT_IRQ_EN2_WMASK;
    end
  end

  assign crystal_stable_irq_en = irq_en[XTAL_EN_BIT];
  assign soft_en = irq_en[SOFT_EN_MSB:SOFT_EN_LSB];
  assign conv_done_irq_en = irq_en[CONV_EN_BIT];
  assign crystal_stable_flag = ext_osc_control[CRYSTAL_STABLE_BIT];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read data registered; it shows the stored value the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && (sfr_addr == EXT_IRQ_EN2_ADDR)) begin
      sfr_rdata <= irq_en;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  assign sfr_hit = (sfr_rd || sfr_wr) && (sfr_addr == EXT_IRQ_EN2_ADDR);

  // ----------------------------------------------------------------
  // masking; flags stay pending in their owners while masked
  // ----------------------------------------------------------------
  irq_gate u_xtal_gate (
    .pending(crystal_stable_flag),
    .enable(crystal_stable_irq_en),
    .request(crystal_stable_req)
  );

  genvar gi;
  generate
    for (gi = 0; gi < SOFT_IRQ_COUNT; gi++) begin : g_soft
      irq_gate u_soft_gate (
        .pending(soft_irq_flag[gi]),
        .enable(soft_en[gi]),
        .request(soft_irq_req[gi])
      );
    end
  endgenerate

  irq_gate u_conv_gate (
    .pending(conv_done_flag),
    .enable(conv_done_irq_en),
    .request(conv_done_req)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_write_en(logic [7:0] d);
    en_write && sfr_wdata == d;
  endsequence

  property p_xtal_gate;
    @(posedge clk) disable iff (!rst_n)
      crystal_stable_req == (ext_osc_control[7] && irq_en[7]);
  endproperty
  a_xtal_gate: assert property (p_xtal_gate)
    else $error("crystal request not gated by bit 7");

  property p_rsvd6;
    @(posedge clk) disable iff (!rst_n)
      sfr_rd && sfr_addr == 8'hE7 |=> !sfr_rdata[6];
  endproperty
  a_rsvd6: assert property (p_rsvd6)
    else $error("reserved bit 6 read nonzero");

  property p_soft_write;
    @(posedge clk) disable iff (!rst_n)
      s_write_en(8'h3C) |=> soft_en == 4'hF;
  endproperty
  a_soft_write: assert property (p_soft_write)
    else $error("soft enables not set by write of 3C");

  property p_soft_req;
    @(posedge clk) disable iff (!rst_n)
      soft_irq_req == (soft_irq_flag & irq_en[5:2]);
  endproperty
  a_soft_req: assert property (p_soft_req)
    else $error("soft request does not follow flag and enable");

  property p_conv;
    @(posedge clk) disable iff (!rst_n)
      conv_done_flag && !irq_en[1] |-> !conv_done_req;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion request leaked while masked");

  property p_rsvd0;
    @(posedge clk) disable iff (!rst_n)
      s_write_en(8'hFF) |=> irq_en == 8'hBE;
  endproperty
  a_rsvd0: assert property (p_rsvd0)
    else $error("reserved bits stored on write");

  property p_read_back;
    @(posedge clk) disable iff (!rst_n)
      sfr_rd && sfr_addr == 8'hE7 |=> sfr_rdata == $past(irq_en);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data differs from enable register");

  property p_xtal_flag;
    @(posedge clk) disable iff (!rst_n)
      irq_en[7] |-> crystal_stable_req == ext_osc_control[7];
  endproperty
  a_xtal_flag: assert property (p_xtal_flag)
    else $error("crystal request not taken from bit 7 of oscillator");

  // ----------------------------------------------------------------
  // register storage and read-back
  // ----------------------------------------------------------------
  // a read in the same cycle as a write returns the old value, so the
  // write-then-read check below waits for a quiet gap first
  sequence s_rd_hit;
    sfr_rd && sfr_addr == EXT_IRQ_EN2_ADDR;
  endsequence

  property p_store;
    @(posedge clk) disable iff (!rst_n)
      en_write |=> irq_en == ($past(sfr_wdata) & EXT_IRQ_EN2_WMASK);
  endproperty
  a_store: assert property (p_store)
    else $error("enable register did not take masked write data");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !en_write |=> irq_en == $past(irq_en);
  endproperty
  a_hold: assert property (p_hold)
    else $error("enable register changed without a write");

  property p_rsvd_bits;
    @(posedge clk) disable iff (!rst_n)
      !irq_en[RSVD_HI_BIT] && !irq_en[RSVD_LO_BIT];
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits)
    else $error("reserved bit held a one");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n)
      !(sfr_rd && sfr_addr == EXT_IRQ_EN2_ADDR) |=> sfr_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read of the register");

  property p_write_read;
    @(posedge clk) disable iff (!rst_n)
      s_write_en(8'h3C) ##1 (!en_write) [*3] ##1 s_rd_hit
        |=> sfr_rdata == 8'h3C;
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("written soft enables not read back");

  // ----------------------------------------------------------------
  // masking of each source
  // ----------------------------------------------------------------
  property p_conv_req;
    @(posedge clk) disable iff (!rst_n)
      conv_done_req == (conv_done_flag && irq_en[CONV_EN_BIT]);
  endproperty
  a_conv_req: assert property (p_conv_req)
    else $error("conversion request does not follow flag and enable");

  property p_xtal_mask;
    @(posedge clk) disable iff (!rst_n)
      !irq_en[XTAL_EN_BIT] |-> !crystal_stable_req;
  endproperty
  a_xtal_mask: assert property (p_xtal_mask)
    else $error("crystal request leaked while masked");

  property p_soft_mask;
    @(posedge clk) disable iff (!rst_n)
      (soft_irq_req & ~soft_en) == '0;
  endproperty
  a_soft_mask: assert property (p_soft_mask)
    else $error("soft request leaked while masked");
endmodule : ext_irq_enable
`default_nettype wire

// File: verif/irq_core_model.sv
// core-side model: the priority logic that sees the masked requests
// assumes requests are levels, sampled on the system clock
`default_nettype none
module irq_core_model (
  input wire logic clk,
  input wire logic [5:0] req,
  output logic [5:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // one edge late, as a real vectoring stage would register them
  always_ff @(posedge clk) begin
    seen <= req;
  end
endmodule : irq_core_model
`default_nettype wire

// File: verif/test_ext_irq_enable.sv
// self-checking bench for the extended interrupt enable mask register
// assumes the irq_mask_pkg constants and the irq_core_model partner
`default_nettype none
module test_ext_irq_enable import irq_mask_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] wd;
    logic [5:0] fl;
    logic [7:0] rd;
    logic [5:0] rq;
  } row_t;
  row_t rows [5] = '{'{8'hFF, 6'h3F, 8'hBE, 6'h3F},
    '{8'h41, 6'h3F, 8'h00, 6'h00}, '{8'h80, 6'h20, 8'h80, 6'h20},
    '{8'h3C, 6'h15, 8'h3C, 6'h14}, '{8'h02, 6'h01, 8'h02, 6'h01}};
  logic clk, rst_n, sfr_wr, sfr_rd, sfr_hit, xr, cr;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [3:0] sr;
  logic [5:0] fl, seen;
  int n_errors = 0;
  int check_count = 0;
  ext_irq_enable ext_irq_enable_inst (.clk(clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .ext_osc_control({fl[5], 7'h7F}), .soft_irq_flag(fl[4:1]),
    .conv_done_flag(fl[0]), .crystal_stable_req(xr),
    .soft_irq_req(sr), .conv_done_req(cr));
  irq_core_model irq_core_model_inst (.clk(clk), .req({xr, sr, cr}),
    .seen(seen));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // one strobe cycle; read data is taken the cycle after the strobe
  task automatic sfr(input logic w, input logic [7:0] a,
      input logic [7:0] v, output logic [7:0] q);
    @(posedge clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= v;
    #1 check({7'h00, sfr_hit}, {7'h00, a === EXT_IRQ_EN2_ADDR});
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1 q = sfr_rdata;
  endtask : sfr
  task automatic summarize;
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, fl} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    sfr(1'b0, EXT_IRQ_EN2_ADDR, 8'h00, d);
    check(d, EXT_IRQ_EN2_RESET);
    foreach (rows[i]) begin
      sfr(1'b1, EXT_IRQ_EN2_ADDR, rows[i].wd, d);
      @(posedge clk);
      fl <= rows[i].fl;
      @(posedge clk);
      #1 check({2'b00, xr, sr, cr}, {2'b00, rows[i].rq});
      check({2'b00, seen}, {2'b00, rows[i].rq});
      sfr(1'b0, EXT_IRQ_EN2_ADDR, 8'h00, d);
      check(d, rows[i].rd);
    end
    // other addresses neither change the register nor read back data
    sfr(1'b1, 8'hE6, 8'hFF, d);
    sfr(1'b0, 8'hE6, 8'h00, d);
    check(d, 8'h00);
    sfr(1'b0, EXT_IRQ_EN2_ADDR, 8'h00, d);
    check(d, 8'h02);
    // low oscillator bits set, stable flag clear: no crystal request
    sfr(1'b1, EXT_IRQ_EN2_ADDR, 8'hFF, d);
    @(posedge clk);
    fl <= 6'h1F;
    @(posedge clk);
    #1 check({7'h00, xr}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1 check({2'b00, xr, sr, cr}, 8'h00);
    sfr(1'b0, EXT_IRQ_EN2_ADDR, 8'h00, d);
    check(d, EXT_IRQ_EN2_RESET);
    summarize();
  end
endmodule : test_ext_irq_enable
`default_nettype wire
